// file: oca_consts.svh
// constants and behaviour list for the character/graphic addressing block
// Behaviour
// - Host writes and refresh reads use separate ports and timing, so a write never disturbs other screen areas.
// - The block drives 16 common outputs and 100 segment outputs.
// - For the chosen font and line count, the active commons carry the scan waveform automatically.
// - Commons that the current line setting does not use carry the non-selection level.
// - Cursor or blink appears at the digit whose text memory address equals the 7-bit address pointer.
// - In one-line mode, positions 1 to 20 map to text addresses 00h to 13h.
// - In two-line mode, line one maps from 00h upward and line two to 40h through 53h.
// - While the pointer selects glyph RAM, the cursor may land at a meaningless position.
// - Character mode holds 128 codes on one line or 64 per line on two lines, line two above 0111111b.
// - A graphic mode holds a 100x16 pixel image with its own addressing.
// - In graphic mode the address command sets column 80h..E3h and command 40h plus a bit sets the half.
`ifndef OCA_CONSTS_SVH
`define OCA_CONSTS_SVH
`define OCA_COM_N 16
`define OCA_SEG_N 100
`define OCA_MEM_AW 8
`define OCA_MEM_DEPTH 256
`define OCA_LINE2_BASE 7'h40
`define OCA_DIGIT_LAST 5'h13
`define OCA_SUB_LAST 3'h4
`define OCA_GLYPH_LAST_ROW 3'h7
`define OCA_COL_LAST 7'h63
`define OCA_CMD_ADDR_BIT 7
`define OCA_CMD_GLYPH_BIT 6
`define OCA_ROWCMD_MASK 8'hFE
`define OCA_ROWCMD_CODE 8'h40
`define OCA_CLK_PERIOD_NS 10
`define OCA_STEP_PERIOD_NS 160
`define OCA_STEP_DIV (`OCA_STEP_PERIOD_NS / `OCA_CLK_PERIOD_NS)
`define OCA_BLINK_FRAMES 6'h1F
`endif

// file: oca_host_model.sv
// host processor model issuing instruction and data bytes
`timescale 1ns/1ps
`default_nettype none
module oca_host_model (
  // clock
  input wire logic clk_sys,
  // host instruction port
  output logic host_wr,
  output logic host_rs,
  output logic [7:0] host_data
);
  initial begin
    host_wr = 1'h0;
    host_rs = 1'h0;
    host_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one byte, one-cycle strobe, bus inverted once released
  task automatic send(input logic rs, input logic [7:0] d);
    @(negedge clk_sys);
    host_wr = 1'h1;
    host_rs = rs;
    host_data = d;
    @(negedge clk_sys);
    host_wr = 1'h0;
    host_data = ~d;
  endtask : send
  // text address byte, top bit set
  task automatic char_addr(input logic [6:0] a);
    send(1'h0, {1'h1, a});
  endtask : char_addr
  // graphic column byte
  task automatic col_addr(input logic [6:0] a);
    send(1'h0, {1'h1, a});
  endtask : col_addr
  // graphic half byte
  task automatic half_sel(input logic h);
    send(1'h0, {7'h20, h});
  endtask : half_sel
endmodule : oca_host_model
`default_nettype wire

// file: oca_mem.sv
// two-port display memory, registered read
`timescale 1ns/1ps
`default_nettype none
`include "oca_consts.svh"
module oca_mem (
  // clock
  input wire logic clk_sys,
  // host write port
  input wire logic wr_en,
  input wire logic [`OCA_MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // refresh read port
  input wire logic [`OCA_MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [0:`OCA_MEM_DEPTH-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem_q[rd_addr];
  end
endmodule : oca_mem
`default_nettype wire

// file: oca_pkg.sv
// types for the character/graphic addressing block
package oca_pkg;
  typedef enum logic {OCA_TGT_TEXT, OCA_TGT_GLYPH} oca_target_type;
  typedef enum logic [2:0] {
    OCA_CMD_NONE, OCA_CMD_ADDR, OCA_CMD_ROW, OCA_CMD_GLYPH, OCA_CMD_DATA
  } oca_cmd_type;
endpackage : oca_pkg

// file: oca_scan.sv
// refresh scan counters: column, digit, sub-column, common
`timescale 1ns/1ps
`default_nettype none
`include "oca_consts.svh"
module oca_scan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // scan position
  output logic step,
  output logic [6:0] col_q,
  output logic [4:0] digit_q,
  output logic [2:0] sub_q,
  output logic [3:0] com_q
);
  logic [7:0] div_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(`OCA_STEP_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign step = (div_q == 8'(`OCA_STEP_DIV - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      col_q <= 7'h00;
      digit_q <= 5'h00;
      sub_q <= 3'h0;
      com_q <= 4'h0;
    end else if (step) begin
      if (col_q == `OCA_COL_LAST) begin
        col_q <= 7'h00;
        digit_q <= 5'h00;
        sub_q <= 3'h0;
        com_q <= com_q + 4'h1;
      end else begin
        col_q <= col_q + 7'h01;
        if (sub_q == `OCA_SUB_LAST) begin
          sub_q <= 3'h0;
          digit_q <= digit_q + 5'h01;
        end else begin
          sub_q <= sub_q + 3'h1;
        end
      end
    end
  end

  property p_col_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    (step && col_q == `OCA_COL_LAST) |=> (col_q == 7'h00 && sub_q == 3'h0);
  endproperty
  a_col_wrap: assert property (p_col_wrap)
    else $error("column did not wrap after last segment");
endmodule : oca_scan
`default_nettype wire

// file: oca_top.sv
// character/graphic addressing, refresh and driver selection
`timescale 1ns/1ps
`default_nettype none
`include "oca_consts.svh"
module oca_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host instruction port
  input wire logic host_wr,
  input wire logic host_rs,
  input wire logic [7:0] host_data,
  // configuration
  input wire logic two_line,
  input wire logic graphic_mode,
  input wire logic cursor_on,
  input wire logic blink_on,
  // glyph rom lookup
  output logic [7:0] glyph_code,
  output logic [2:0] glyph_row,
  input wire logic [4:0] glyph_bits,
  // status
  output logic [6:0] address_pointer,
  output logic ptr_in_glyph_ram,
  output logic [6:0] graphic_col,
  output logic row_half_select,
  // panel drivers
  output logic [`OCA_COM_N-1:0] com_out,
  output logic [`OCA_SEG_N-1:0] seg_out
);
  ////////////////////////////////////////////////////////////////////////////
  // host decode
  oca_pkg::oca_cmd_type cmd;
  oca_pkg::oca_target_type tgt_q;
  logic [6:0] ptr_q;
  logic [6:0] gcol_q;
  logic half_q;
  logic mem_we;
  logic [`OCA_MEM_AW-1:0] mem_wa;

  always_comb begin
    cmd = oca_pkg::OCA_CMD_NONE;
    if (host_wr && host_rs) begin
      cmd = oca_pkg::OCA_CMD_DATA;
    end else if (host_wr && host_data[`OCA_CMD_ADDR_BIT]) begin
      cmd = oca_pkg::OCA_CMD_ADDR;
    end else if (host_wr && graphic_mode &&
                 (host_data & `OCA_ROWCMD_MASK) == `OCA_ROWCMD_CODE) begin
      cmd = oca_pkg::OCA_CMD_ROW;
    end else if (host_wr && host_data[`OCA_CMD_GLYPH_BIT]) begin
      cmd = oca_pkg::OCA_CMD_GLYPH;
    end
  end

  // character address and glyph pointer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_q <= 7'h00;
      tgt_q <= oca_pkg::OCA_TGT_TEXT;
    end else begin
      case (cmd)
        oca_pkg::OCA_CMD_ADDR: begin
          if (!graphic_mode) begin
            ptr_q <= host_data[6:0];
            tgt_q <= oca_pkg::OCA_TGT_TEXT;
          end
        end
        oca_pkg::OCA_CMD_GLYPH: begin
          ptr_q <= {1'b0, host_data[5:0]};
          tgt_q <= oca_pkg::OCA_TGT_GLYPH;
        end
        oca_pkg::OCA_CMD_DATA: begin
          if (!graphic_mode) begin
            ptr_q <= ptr_q + 7'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // graphic column and half
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gcol_q <= 7'h00;
      half_q <= 1'b0;
    end else begin
      case (cmd)
        oca_pkg::OCA_CMD_ADDR: begin
          if (graphic_mode && host_data[6:0] <= `OCA_COL_LAST) begin
            gcol_q <= host_data[6:0];
          end
        end
        oca_pkg::OCA_CMD_ROW: begin
          half_q <= host_data[0];
        end
        oca_pkg::OCA_CMD_DATA: begin
          if (graphic_mode) begin
            gcol_q <= (gcol_q == `OCA_COL_LAST) ? 7'h00 : gcol_q + 7'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // graphic byte lands at {half, column}; text at pointer
  assign mem_we = (cmd == oca_pkg::OCA_CMD_DATA) &&
                  (graphic_mode || tgt_q == oca_pkg::OCA_TGT_TEXT);
  assign mem_wa = graphic_mode ? {half_q, gcol_q} : {1'b0, ptr_q};

  assign address_pointer = ptr_q;
  assign ptr_in_glyph_ram = (tgt_q == oca_pkg::OCA_TGT_GLYPH);
  assign graphic_col = gcol_q;
  assign row_half_select = half_q;

  ////////////////////////////////////////////////////////////////////////////
  // refresh scan
  logic step;
  logic [6:0] col;
  logic [4:0] digit;
  logic [2:0] sub;
  logic [3:0] com;
  logic [6:0] text_addr;
  logic [`OCA_MEM_AW-1:0] rd_addr;
  logic [7:0] rd_data;

  oca_scan u_scan (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .step(step),
    .col_q(col),
    .digit_q(digit),
    .sub_q(sub),
    .com_q(com)
  );

  // line two reads from 40h, line one from 00h
  assign text_addr = (two_line && com[3]) ?
                     (`OCA_LINE2_BASE + {2'b00, digit}) :
                     {2'b00, digit};
  assign rd_addr = graphic_mode ? {com[3], col} : {1'b0, text_addr};

  // separate read port keeps refresh apart from host writes
  oca_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(host_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pixel stage
  logic s1_q;
  logic [6:0] s1_col_q;
  logic [2:0] s1_sub_q;
  logic [3:0] s1_com_q;
  logic [6:0] s1_addr_q;
  logic [5:0] blink_cnt_q;
  logic blink_ph_q;
  logic line_act;
  logic hit;
  logic pix;
  logic [`OCA_SEG_N-1:0] line_q;
  logic [`OCA_SEG_N-1:0] line_full;
  logic [`OCA_COM_N-1:0] com_d;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s1_col_q <= 7'h00;
      s1_sub_q <= 3'h0;
      s1_com_q <= 4'h0;
      s1_addr_q <= 7'h00;
    end else begin
      s1_q <= step;
      if (step) begin
        s1_col_q <= col;
        s1_sub_q <= sub;
        s1_com_q <= com;
        s1_addr_q <= text_addr;
      end
    end
  end

  // blink phase flips every few frames
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blink_cnt_q <= 6'h00;
      blink_ph_q <= 1'b0;
    end else if (s1_q && s1_col_q == `OCA_COL_LAST &&
                 s1_com_q == 4'hF) begin
      if (blink_cnt_q == `OCA_BLINK_FRAMES) begin
        blink_cnt_q <= 6'h00;
        blink_ph_q <= ~blink_ph_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 6'h01;
      end
    end
  end

  assign glyph_code = rd_data;
  assign glyph_row = s1_com_q[2:0];

  // one-line text uses only the lower eight commons
  assign line_act = graphic_mode || two_line || !s1_com_q[3];
  assign hit = (s1_addr_q == ptr_q);

  always_comb begin
    pix = 1'b0;
    if (!line_act) begin
      pix = 1'b0;
    end else if (graphic_mode) begin
      pix = rd_data[s1_com_q[2:0]];
    end else if (hit && blink_on && blink_ph_q) begin
      pix = 1'b1;
    end else if (hit && cursor_on &&
                 s1_com_q[2:0] == `OCA_GLYPH_LAST_ROW) begin
      pix = 1'b1;
    end else if (s1_sub_q <= `OCA_SUB_LAST) begin
      pix = glyph_bits[3'(`OCA_SUB_LAST - s1_sub_q)];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      line_q <= '0;
    end else if (s1_q) begin
      line_q[s1_col_q] <= pix;
    end
  end

  always_comb begin
    line_full = line_q;
    line_full[`OCA_SEG_N-1] = pix;
  end

  // common selection: one-hot on active line, rest non-selection
  genvar gi;
  generate
    for (gi = 0; gi < `OCA_COM_N; gi = gi + 1) begin : g_com
      assign com_d[gi] = line_act && (s1_com_q == 4'(gi));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seg_out <= '0;
      com_out <= '0;
    end else if (s1_q && s1_col_q == `OCA_COL_LAST) begin
      seg_out <= line_full;
      com_out <= com_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_row_end;
    s1_q && s1_col_q == `OCA_COL_LAST;
  endsequence

  property p_addr_cmd;
    @(posedge clk_sys) disable iff (!rst_n)
    (host_wr && !host_rs && host_data[7] && !graphic_mode)
      |=> (ptr_q == $past(host_data[6:0]) && !ptr_in_glyph_ram);
  endproperty
  a_addr_cmd: assert property (p_addr_cmd)
    else $error("address command did not load pointer");

  property p_text_inc;
    @(posedge clk_sys) disable iff (!rst_n)
    (host_wr && host_rs && !graphic_mode)
      |=> (ptr_q == $past(ptr_q) + 7'h01);
  endproperty
  a_text_inc: assert property (p_text_inc)
    else $error("pointer did not advance after text write");

  property p_gfx_col;
    @(posedge clk_sys) disable iff (!rst_n)
    (host_wr && !host_rs && host_data[7] && graphic_mode &&
     host_data[6:0] <= 7'h63) |=> (gcol_q == $past(host_data[6:0]));
  endproperty
  a_gfx_col: assert property (p_gfx_col)
    else $error("column command not taken");

  property p_gfx_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    (host_wr && host_rs && graphic_mode && gcol_q == 7'h63)
      |=> (gcol_q == 7'h00);
  endproperty
  a_gfx_wrap: assert property (p_gfx_wrap)
    else $error("graphic column did not wrap after 100");

  property p_gfx_wr;
    @(posedge clk_sys) disable iff (!rst_n)
    (host_wr && host_rs && graphic_mode)
      |-> (mem_we && mem_wa == {half_q, gcol_q});
  endproperty
  a_gfx_wr: assert property (p_gfx_wr)
    else $error("graphic byte sent to wrong address");

  property p_com_onehot;
    @(posedge clk_sys) disable iff (!rst_n)
    $onehot0(com_out);
  endproperty
  a_com_onehot: assert property (p_com_onehot)
    else $error("more than one common selected");

  property p_com_unused;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_row_end and (!graphic_mode && !two_line)) |=> (com_out[15:8] == 8'h00);
  endproperty
  a_com_unused: assert property (p_com_unused)
    else $error("unused common driven in one-line mode");

  property p_seg_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    s_row_end |=> (seg_out[`OCA_SEG_N-1] == $past(pix));
  endproperty
  a_seg_latch: assert property (p_seg_latch)
    else $error("last segment not latched");

  property p_line2_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (step && !graphic_mode && two_line && com[3])
      |-> (rd_addr[6] && rd_addr[5:0] <= 6'h13);
  endproperty
  a_line2_addr: assert property (p_line2_addr)
    else $error("second line read outside 40h..53h");

  property p_line1_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (step && !graphic_mode && !two_line) |-> (rd_addr <= 8'h13);
  endproperty
  a_line1_addr: assert property (p_line1_addr)
    else $error("one-line read outside 00h..13h");
endmodule : oca_top
`default_nettype wire

// file: tb_oca_top.sv
// self-checking bench for the addressing block
`timescale 1ns/1ps
`default_nettype none
`include "oca_consts.svh"
module tb_oca_top;
  typedef struct packed {
    logic rs;
    logic [7:0] d;
    logic gm;
    logic ck;
    logic [6:0] p;
    logic g;
    logic [6:0] c;
    logic h;
  } oca_row_type;
  logic clk_sys, rst_n, host_wr, host_rs;
  logic two_line, graphic_mode, cursor_on, blink_on;
  logic [7:0] host_data, glyph_code;
  logic [2:0] glyph_row;
  logic [4:0] glyph_bits;
  logic [6:0] address_pointer, graphic_col;
  logic ptr_in_glyph_ram, row_half_select;
  logic [`OCA_COM_N-1:0] com_out;
  logic [`OCA_SEG_N-1:0] seg_out;
  int error_cnt = 0;
  int n_tests = 0;
  int hi_cnt = 0;
  oca_row_type rows [11];
  ////////////////////////////////////////////////////////////////////////////
  // glyph rom stand-in: row pattern is the low code bits
  assign glyph_bits = glyph_code[4:0];
  oca_host_model host (.clk_sys(clk_sys), .host_wr(host_wr),
    .host_rs(host_rs), .host_data(host_data));
  oca_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .host_wr(host_wr),
    .host_rs(host_rs), .host_data(host_data), .two_line(two_line),
    .graphic_mode(graphic_mode), .cursor_on(cursor_on),
    .blink_on(blink_on), .glyph_code(glyph_code), .glyph_row(glyph_row),
    .glyph_bits(glyph_bits), .address_pointer(address_pointer),
    .ptr_in_glyph_ram(ptr_in_glyph_ram), .graphic_col(graphic_col),
    .row_half_select(row_half_select), .com_out(com_out),
    .seg_out(seg_out));
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // upper commons driven in one-line text
  always @(negedge clk_sys) begin
    if (!two_line && !graphic_mode && |com_out[15:8]) hi_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [6:0] e,
    input logic [6:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_seg(input string n, input logic [4:0] e,
    input logic [4:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_seg
  // bounded wait for common k to be shown
  task automatic wait_row(input int k);
    int i;
    for (i = 0; i < 30000 && com_out !== (16'h0001 << k); i++)
      @(negedge clk_sys);
    if (i == 30000) begin
      error_cnt++;
      $display("[ERR] com_out exp %h got %h", 16'h0001 << k, com_out);
    end
  endtask : wait_row
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0;
    two_line = 1'h0;
    graphic_mode = 1'h0;
    cursor_on = 1'h0;
    blink_on = 1'h0;
    rows = '{'{0, 8'h8E, 0, 1, 7'h0E, 0, 7'h00, 0},
      '{0, 8'hC6, 0, 1, 7'h46, 0, 7'h00, 0},
      '{0, 8'hBF, 0, 1, 7'h3F, 0, 7'h00, 0},
      '{1, 8'h41, 0, 1, 7'h40, 0, 7'h00, 0},
      '{0, 8'h45, 0, 1, 7'h05, 1, 7'h00, 0},
      '{1, 8'h00, 0, 1, 7'h06, 1, 7'h00, 0},
      '{0, 8'hE3, 1, 1, 7'h06, 1, 7'h63, 0},
      '{0, 8'hE4, 1, 1, 7'h06, 1, 7'h63, 0},
      '{0, 8'h41, 1, 1, 7'h06, 1, 7'h63, 1},
      '{1, 8'h55, 1, 0, 7'h00, 0, 7'h00, 1},
      '{0, 8'h40, 1, 0, 7'h00, 0, 7'h00, 0}};
    repeat (2) @(negedge clk_sys);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      graphic_mode = rows[i].gm;
      host.send(rows[i].rs, rows[i].d);
      if (rows[i].ck) begin
        chk("pointer", rows[i].p, address_pointer);
        chk("glyph", {6'h00, rows[i].g}, {6'h00, ptr_in_glyph_ram});
      end
      chk("column", rows[i].c, graphic_col);
      chk("half", {6'h00, rows[i].h}, {6'h00, row_half_select});
    end
    $display("test table done");
    host.col_addr(7'h21);
    host.half_sel(1'h1);
    chk("column set", 7'h21, graphic_col);
    graphic_mode = 1'h0;
    rst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("reset pointer", 7'h00, address_pointer);
    chk("reset column", 7'h00, graphic_col);
    chk("reset half", 7'h00, {6'h00, row_half_select});
    chk("reset target", 7'h00, {6'h00, ptr_in_glyph_ram});
    rst_n = 1'h1;
    $display("test reset done");
    host.char_addr(7'h00);
    host.send(1'h1, 8'h03);
    host.char_addr(7'h40);
    host.send(1'h1, 8'h0A);
    host.char_addr(7'h01);
    cursor_on = 1'h1;
    blink_on = 1'h1;
    wait_row(7);
    chk("glyph row", 7'h07, {4'h0, glyph_row});
    chk_seg("cursor", 5'h1F, seg_out[9:5]);
    chk_seg("digit one", 5'h18, seg_out[4:0]);
    wait_row(0);
    chk("upper commons", 7'h00, {6'h00, hi_cnt != 0});
    two_line = 1'h1;
    wait_row(8);
    chk_seg("line two", 5'h0A, seg_out[4:0]);
    $display("test text panel done");
    cursor_on = 1'h0;
    graphic_mode = 1'h1;
    host.half_sel(1'h0);
    host.col_addr(7'h00);
    host.send(1'h1, 8'h01);
    wait_row(0);
    chk_seg("pixel top", 5'h01, {4'h0, seg_out[0]});
    wait_row(1);
    chk_seg("pixel next", 5'h00, {4'h0, seg_out[0]});
    $display("test graphic panel done");
    rst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("reset com", 7'h00, {6'h00, |com_out});
    chk("reset seg", 7'h00, {6'h00, |seg_out});
    chk("reset column 2", 7'h00, graphic_col);
    rst_n = 1'h1;
    repeat (2) @(negedge clk_sys);
    chk("restart com", 7'h00, {6'h00, |com_out});
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb_oca_top
`default_nettype wire
